// file: src/spl_consts.svh
// Offsets, field positions, codes and reset values of the page load engine
`ifndef SPL_CONSTS_SVH
`define SPL_CONSTS_SVH
// ==========================================
// Register byte offsets
`define SPL_OFF_CTRL 8'h00
`define SPL_OFF_DESC 8'h04
`define SPL_OFF_DEST 8'h08
`define SPL_OFF_SLOT 8'h0c
`define SPL_OFF_META 8'h10
`define SPL_OFF_SRC 8'h14
`define SPL_OFF_CPAGE 8'h18
`define SPL_OFF_LIN 8'h1c
`define SPL_OFF_SEC_INFO 8'h20
`define SPL_OFF_COND 8'h24
`define SPL_OFF_CPAGE_ID 8'h28
`define SPL_OFF_TAG_STORED 8'h2c
`define SPL_OFF_TAG_CALC 8'h30
`define SPL_OFF_VER_LO 8'h34
`define SPL_OFF_VER_HI 8'h38
`define SPL_OFF_STATUS 8'h3c
`define SPL_OFF_RESULT 8'h40
`define SPL_OFF_MAP 8'h44
`define SPL_OFF_HDR_ID 8'h48
`define SPL_OFF_CONTEXT 8'h4c
`define SPL_OFF_FAULT_ADDR 8'h50
`define SPL_OFF_COUNTER_HI 8'h54
`define SPL_OFF_MAP_LIN 8'h58
// ==========================================
// Field positions
`define SPL_CTRL_START_BIT 8
`define SPL_STAT_BUSY_BIT 8
`define SPL_STAT_ZERO_BIT 9
`define SPL_STAT_CARRY_BIT 10
// ==========================================
// Leaf codes
`define SPL_LEAF_BLK 8'h07
`define SPL_LEAF_UNBLK 8'h08
`define SPL_LEAF_BLK_C 8'h12
`define SPL_LEAF_UNBLK_C 8'h13
// ==========================================
// Page type encodings
`define SPL_PT_CONTROL 8'h00
`define SPL_PT_REGULAR 8'h01
`define SPL_PT_THREAD 8'h02
`define SPL_PT_VERSION 8'h03
`define SPL_PT_TRIMMED 8'h04
`define SPL_PT_SHADOW_FIRST 8'h05
`define SPL_PT_SHADOW_REST 8'h06
// ==========================================
// Result codes
`define SPL_CODE_OK 32'h0000_0000
`define SPL_CODE_TAG_MISMATCH 32'h0000_0004
`define SPL_CODE_PAGE_CONFLICT 32'h0000_0007
// ==========================================
// Reset values
`define SPL_RST_WORD 32'h0000_0000
`define SPL_RST_MAP 16'h0000
`endif

// file: src/spl_engine.sv
// Page load engine with AHB-Lite register slave
`timescale 1ns/1ps
`include "spl_consts.svh"
module spl_engine
  import spl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Status
  output logic busy
);

  // ==========================================
  // Registers
  spl_state_t st_q;
  logic [7:0] leaf_q;
  logic [31:0] desc_q, dest_q, slot_q, meta_q, src_q, cpage_q, lin_q;
  spl_security_info_t sec_q;
  spl_cond_t cond_q;
  logic [31:0] cpage_id_q, tag_st_q, tag_calc_q, ver_lo_q, ver_hi_q;
  spl_outcome_t out_q;
  logic zero_flag_q, carry_flag_q;
  logic [31:0] code_q, hdr_id_q, ctx_q, fault_addr_q, map_lin_q;
  spl_map_t map_q;
  logic [31:0] hrdata_q;
  logic wr_q, busy_q;
  logic [7:0] wa_q;
  logic start;
  spl_check_t res;

  // ==========================================
  // Bus slave
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    case (a)
      `SPL_OFF_CTRL: rd_word = {24'h0, leaf_q};
      `SPL_OFF_DESC: rd_word = desc_q;
      `SPL_OFF_DEST: rd_word = dest_q;
      `SPL_OFF_SLOT: rd_word = slot_q;
      `SPL_OFF_META: rd_word = meta_q;
      `SPL_OFF_SRC: rd_word = src_q;
      `SPL_OFF_CPAGE: rd_word = cpage_q;
      `SPL_OFF_LIN: rd_word = lin_q;
      `SPL_OFF_SEC_INFO: rd_word = {18'h0, sec_q};
      `SPL_OFF_COND: rd_word = {18'h0, cond_q};
      `SPL_OFF_CPAGE_ID: rd_word = cpage_id_q;
      `SPL_OFF_TAG_STORED: rd_word = tag_st_q;
      `SPL_OFF_TAG_CALC: rd_word = tag_calc_q;
      `SPL_OFF_VER_LO: rd_word = ver_lo_q;
      `SPL_OFF_VER_HI: rd_word = ver_hi_q;
      `SPL_OFF_STATUS: rd_word = {21'h0, carry_flag_q, zero_flag_q, busy_q, 4'h0, out_q};
      `SPL_OFF_RESULT: rd_word = code_q;
      `SPL_OFF_MAP: rd_word = {16'h0, map_q};
      `SPL_OFF_HDR_ID: rd_word = hdr_id_q;
      `SPL_OFF_CONTEXT: rd_word = ctx_q;
      `SPL_OFF_FAULT_ADDR: rd_word = fault_addr_q;
      `SPL_OFF_MAP_LIN: rd_word = map_lin_q;
      // Counter upper word is the version's low word, lower word zero
      `SPL_OFF_COUNTER_HI: rd_word = ver_lo_q;
      default: rd_word = 32'h0;
    endcase
  endfunction

  wire logic aphase = hsel && hready && htrans[1];

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      hrdata_q <= `SPL_RST_WORD;
    end
    else
    begin
      wr_q <= aphase && hwrite;
      wa_q <= haddr[7:0];
      // Read data captured in the address phase so hrdata is a flop
      if (aphase && !hwrite)
        hrdata_q <= (haddr[31:8] == 24'h0) ? rd_word(haddr[7:0]) : 32'h0;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign busy = busy_q;

  assign start = wr_q && (wa_q == `SPL_OFF_CTRL) && hwdata[`SPL_CTRL_START_BIT]
                 && (st_q == SPL_ST_IDLE);

  // Operand registers; held constant while a load is in flight
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      leaf_q <= 8'h00;
      desc_q <= `SPL_RST_WORD;
      dest_q <= `SPL_RST_WORD;
      slot_q <= `SPL_RST_WORD;
      meta_q <= `SPL_RST_WORD;
      src_q <= `SPL_RST_WORD;
      cpage_q <= `SPL_RST_WORD;
      lin_q <= `SPL_RST_WORD;
      sec_q <= '0;
      cond_q <= '0;
      cpage_id_q <= `SPL_RST_WORD;
      tag_st_q <= `SPL_RST_WORD;
      tag_calc_q <= `SPL_RST_WORD;
    end
    else if (wr_q && st_q == SPL_ST_IDLE)
    begin
      case (wa_q)
        `SPL_OFF_CTRL: leaf_q <= hwdata[7:0];
        `SPL_OFF_DESC: desc_q <= hwdata;
        `SPL_OFF_DEST: dest_q <= hwdata;
        `SPL_OFF_SLOT: slot_q <= hwdata;
        `SPL_OFF_META: meta_q <= hwdata;
        `SPL_OFF_SRC: src_q <= hwdata;
        `SPL_OFF_CPAGE: cpage_q <= hwdata;
        `SPL_OFF_LIN: lin_q <= hwdata;
        `SPL_OFF_SEC_INFO: sec_q <= hwdata[13:0];
        `SPL_OFF_COND: cond_q <= hwdata[13:0];
        `SPL_OFF_CPAGE_ID: cpage_id_q <= hwdata;
        `SPL_OFF_TAG_STORED: tag_st_q <= hwdata;
        `SPL_OFF_TAG_CALC: tag_calc_q <= hwdata;
        default: ;
      endcase
    end
  end

  // ==========================================
  // Checks, in the order the load performs them
  wire logic leaf_code = (leaf_q == `SPL_LEAF_BLK_C) || (leaf_q == `SPL_LEAF_UNBLK_C);
  wire logic leaf_known = leaf_code || (leaf_q == `SPL_LEAF_BLK)
                          || (leaf_q == `SPL_LEAF_UNBLK);
  wire logic parented = (sec_q.ptype == `SPL_PT_REGULAR) || (sec_q.ptype == `SPL_PT_THREAD)
                        || (sec_q.ptype == `SPL_PT_TRIMMED)
                        || (cond_q.feat_ss && ((sec_q.ptype == `SPL_PT_SHADOW_FIRST)
                        || (sec_q.ptype == `SPL_PT_SHADOW_REST)));
  wire logic no_parent = (sec_q.ptype == `SPL_PT_CONTROL) || (sec_q.ptype == `SPL_PT_VERSION);
  wire spl_check_t conflict_res = leaf_code
       ? spl_check_t'{kind: SPL_OC_ERR, code: `SPL_CODE_PAGE_CONFLICT, addr: 32'h0}
       : spl_check_t'{kind: SPL_OC_GP, code: 32'h0, addr: 32'h0};

  always_comb
  begin
    res = '{kind: SPL_OC_OK, code: `SPL_CODE_OK, addr: 32'h0};
    if (!leaf_known || !cond_q.cpl_zero)
      res.kind = SPL_OC_GP;
    else if (cond_q.long_mode && cond_q.noncanonical)
      res.kind = SPL_OC_GP;
    else if ((desc_q[4:0] != 5'h0) || (dest_q[11:0] != 12'h0))
      res.kind = SPL_OC_GP;
    else if (!cond_q.dest_in_cache)
      res = '{kind: SPL_OC_PF, code: 32'h0, addr: dest_q};
    else if (slot_q[2:0] != 3'h0)
      res.kind = SPL_OC_GP;
    else if (!cond_q.slot_in_cache)
      res = '{kind: SPL_OC_PF, code: 32'h0, addr: slot_q};
    else if ((meta_q[6:0] != 7'h0) || (src_q[11:0] != 12'h0))
      res.kind = SPL_OC_GP;
    else if (cond_q.dest_conflict)
    begin
      // Guest exits carry the destination as the faulting address
      if (cond_q.guest_ext)
        res = '{kind: leaf_code ? SPL_OC_VMX_ERR : SPL_OC_VMX_EXC,
                code: leaf_code ? `SPL_CODE_PAGE_CONFLICT : 32'h0, addr: dest_q};
      else
        res = conflict_res;
    end
    else if (cond_q.slot_conflict)
      res = conflict_res;
    else if (cond_q.dest_valid)
      res = '{kind: SPL_OC_PF, code: 32'h0, addr: dest_q};
    else if (!cond_q.slot_page_valid || !cond_q.slot_is_version)
      res = '{kind: SPL_OC_PF, code: 32'h0, addr: slot_q};
    else if (parented && (cpage_q[11:0] != 12'h0))
      res.kind = SPL_OC_GP;
    else if (parented && !cond_q.cpage_in_cache)
      res = '{kind: SPL_OC_PF, code: 32'h0, addr: cpage_q};
    else if (parented && cond_q.cpage_conflict)
      res = conflict_res;
    else if (!parented && (cpage_q != 32'h0))
      res.kind = SPL_OC_GP;
    else if (tag_calc_q != tag_st_q)
      res = '{kind: SPL_OC_ERR, code: `SPL_CODE_TAG_MISMATCH, addr: 32'h0};
  end

  // ==========================================
  // Sequencer
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      st_q <= SPL_ST_IDLE;
    else
    begin
      case (st_q)
        SPL_ST_IDLE: st_q <= start ? SPL_ST_CHECK : SPL_ST_IDLE;
        SPL_ST_CHECK: st_q <= SPL_ST_DONE;
        SPL_ST_DONE: st_q <= SPL_ST_IDLE;
        default: st_q <= SPL_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      busy_q <= 1'b0;
    else
      busy_q <= (st_q == SPL_ST_IDLE) ? start : (st_q == SPL_ST_CHECK);
  end

  // Outcome, flags and result code
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_q <= SPL_OC_NONE;
      zero_flag_q <= 1'b0;
      carry_flag_q <= 1'b0;
      code_q <= `SPL_RST_WORD;
      fault_addr_q <= `SPL_RST_WORD;
    end
    else if (start)
      out_q <= SPL_OC_NONE;
    else if (st_q == SPL_ST_CHECK)
    begin
      out_q <= res.kind;
      fault_addr_q <= res.addr;
      // Faults and exits leave the flags and result code alone
      if (res.kind == SPL_OC_OK || res.kind == SPL_OC_ERR)
      begin
        zero_flag_q <= (res.kind == SPL_OC_ERR);
        carry_flag_q <= 1'b0;
        code_q <= res.code;
      end
    end
  end

  // Header build; identifier zero unless a parent page is bound
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      hdr_id_q <= `SPL_RST_WORD;
    else if (start)
      hdr_id_q <= 32'h0;
    else if (st_q == SPL_ST_CHECK)
      hdr_id_q <= parented ? cpage_id_q : 32'h0;
  end

  // Commit happens only after every check above has passed
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      map_q <= `SPL_RST_MAP;
      ctx_q <= `SPL_RST_WORD;
      map_lin_q <= `SPL_RST_WORD;
    end
    else if (st_q == SPL_ST_CHECK && res.kind == SPL_OC_OK)
    begin
      map_q.sec <= sec_q;
      map_q.blocked <= ((leaf_q == `SPL_LEAF_BLK) || (leaf_q == `SPL_LEAF_BLK_C))
                       && !no_parent;
      map_q.valid <= 1'b1;
      map_lin_q <= lin_q;
      // Paging is identity here, so the translation is the pointer
      if (sec_q.ptype == `SPL_PT_CONTROL)
        ctx_q <= dest_q;
    end
  end

  // Version slot: read as the counter, zeroed on success
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ver_lo_q <= `SPL_RST_WORD;
      ver_hi_q <= `SPL_RST_WORD;
    end
    else if (st_q == SPL_ST_CHECK && res.kind == SPL_OC_OK)
    begin
      ver_lo_q <= 32'h0;
      ver_hi_q <= 32'h0;
    end
    else if (wr_q && st_q == SPL_ST_IDLE && wa_q == `SPL_OFF_VER_LO)
      ver_lo_q <= hwdata;
    else if (wr_q && st_q == SPL_ST_IDLE && wa_q == `SPL_OFF_VER_HI)
      ver_hi_q <= hwdata;
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence load_steps;
    st_q == SPL_ST_CHECK ##1 st_q == SPL_ST_DONE ##1 st_q == SPL_ST_IDLE;
  endsequence

  load_walk_a: assert property (start |=> load_steps)
    else $error("load did not walk check, done, idle");
  priv_check_a: assert property (st_q == SPL_ST_CHECK && !cond_q.cpl_zero
    |=> out_q == SPL_OC_GP)
    else $error("load accepted outside privilege zero");
  leaf_check_a: assert property (st_q == SPL_ST_CHECK && !leaf_known
    |=> out_q == SPL_OC_GP)
    else $error("unknown leaf not refused");
  desc_align_a: assert property (st_q == SPL_ST_CHECK && cond_q.cpl_zero && leaf_known
    && !(cond_q.long_mode && cond_q.noncanonical) && desc_q[4:0] != 5'h0
    |=> out_q == SPL_OC_GP)
    else $error("misaligned descriptor not faulted");
  commit_gate_a: assert property ($changed(map_q) |-> out_q == SPL_OC_OK
    && $past(st_q) == SPL_ST_CHECK)
    else $error("entry changed without successful load");
  tag_fail_a: assert property (st_q == SPL_ST_CHECK && res.kind == SPL_OC_ERR
    && tag_calc_q != tag_st_q && res.code == `SPL_CODE_TAG_MISMATCH
    |=> zero_flag_q && code_q == `SPL_CODE_TAG_MISMATCH && !carry_flag_q)
    else $error("tag mismatch not reported");
  slot_clear_a: assert property (st_q == SPL_ST_CHECK && res.kind == SPL_OC_OK
    |=> ver_lo_q == 32'h0 && ver_hi_q == 32'h0 && map_q.valid && !zero_flag_q)
    else $error("success did not clear slot and mark valid");
  blocked_bit_a: assert property (st_q == SPL_ST_CHECK && res.kind == SPL_OC_OK
    |=> map_q.blocked == ((($past(leaf_q) == `SPL_LEAF_BLK)
    || ($past(leaf_q) == `SPL_LEAF_BLK_C)) && !$past(no_parent)))
    else $error("blocked bit wrong after load");
  code_conflict_a: assert property (st_q == SPL_ST_CHECK && leaf_code
    && res.kind == SPL_OC_ERR && res.code == `SPL_CODE_PAGE_CONFLICT
    |=> out_q == SPL_OC_ERR && zero_flag_q && code_q == `SPL_CODE_PAGE_CONFLICT)
    else $error("conflict code not returned");
endmodule

// file: src/spl_pkg.sv
// Types shared by the page load engine
package spl_pkg;
  typedef enum logic [2:0]
  {
    SPL_ST_IDLE = 3'h1,
    SPL_ST_CHECK = 3'h2,
    SPL_ST_DONE = 3'h4
  } spl_state_t;
  typedef enum logic [3:0]
  {
    SPL_OC_NONE = 4'h0,
    SPL_OC_OK = 4'h1,
    SPL_OC_GP = 4'h2,
    SPL_OC_PF = 4'h3,
    SPL_OC_VMX_EXC = 4'h4,
    SPL_OC_VMX_ERR = 4'h5,
    SPL_OC_ERR = 4'h6
  } spl_outcome_t;
  typedef struct packed
  {
    logic feat_ss;
    logic guest_ext;
    logic slot_is_version;
    logic slot_page_valid;
    logic dest_valid;
    logic cpage_conflict;
    logic slot_conflict;
    logic dest_conflict;
    logic cpage_in_cache;
    logic slot_in_cache;
    logic dest_in_cache;
    logic noncanonical;
    logic long_mode;
    logic cpl_zero;
  } spl_cond_t;
  typedef struct packed
  {
    logic restriction_pending;
    logic modified;
    logic pending;
    logic [2:0] rwx;
    logic [7:0] ptype;
  } spl_security_info_t;
  typedef struct packed
  {
    logic valid;
    logic blocked;
    spl_security_info_t sec;
  } spl_map_t;
  typedef struct packed
  {
    spl_outcome_t kind;
    logic [31:0] code;
    logic [31:0] addr;
  } spl_check_t;
endpackage

// file: test/spl_engine_tb.sv
// Self-checking bench for the page load engine
`timescale 1ns/1ps
`include "spl_consts.svh"
module spl_engine_tb
  import spl_pkg::*;
;
  logic clk_sys, reset_n, hsel, hwrite, hreadyout, hresp, busy;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [31:0] desc, dest, slot, meta, src, cp, tagc, sec, st, rs, mp, v;
  logic [15:0] emap;
  logic [7:0] lf [4] = '{`SPL_LEAF_BLK, `SPL_LEAF_UNBLK, `SPL_LEAF_BLK_C, `SPL_LEAF_UNBLK_C};
  spl_cond_t c;
  int miscompares, n_tests, cyc;
  spl_engine u_spl_engine (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .busy(busy));
  spl_host_model u_spl_host_model (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata));
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Whole run is a few thousand cycles; this only catches a hang
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      conclude();
    end
  end
  // ==========================================
  // Common tasks
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_spl_host_model.xfer(1'b1, {24'h0, a}, d, v);
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    u_spl_host_model.xfer(1'b0, {24'h0, a}, 32'h0, v);
    cmp(what, exp, v);
  endtask
  task automatic base();
    desc = 32'h0000_1000;
    dest = 32'h0020_0000;
    slot = 32'h0030_0008;
    meta = 32'h0000_2080;
    src = 32'h0000_5000;
    cp = 32'h0040_0000;
    tagc = 32'h1234_5678;
    sec = 32'h0000_0f01;
    c = '0;
    c.cpl_zero = 1'b1;
    c.long_mode = 1'b1;
    c.dest_in_cache = 1'b1;
    c.slot_in_cache = 1'b1;
    c.cpage_in_cache = 1'b1;
    c.slot_page_valid = 1'b1;
    c.slot_is_version = 1'b1;
  endtask
  task automatic go(input logic [7:0] leaf);
    wr(`SPL_OFF_DESC, desc);
    wr(`SPL_OFF_DEST, dest);
    wr(`SPL_OFF_SLOT, slot);
    wr(`SPL_OFF_META, meta);
    wr(`SPL_OFF_SRC, src);
    wr(`SPL_OFF_CPAGE, cp);
    wr(`SPL_OFF_LIN, 32'h7000_0000);
    wr(`SPL_OFF_SEC_INFO, sec);
    wr(`SPL_OFF_COND, {18'h0, c});
    wr(`SPL_OFF_CPAGE_ID, 32'h0000_00a5);
    wr(`SPL_OFF_TAG_STORED, 32'h1234_5678);
    wr(`SPL_OFF_TAG_CALC, tagc);
    wr(`SPL_OFF_VER_LO, 32'h0000_0011);
    wr(`SPL_OFF_VER_HI, 32'h0000_0022);
    wr(`SPL_OFF_CTRL, {23'h0, 1'b1, leaf});
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clk_sys);
      #1;
      if (i == 0)
        cmp("busy", 32'h1, {31'h0, busy});
      if (i > 0 && busy === 1'b0)
        break;
    end
    u_spl_host_model.xfer(1'b0, {24'h0, `SPL_OFF_STATUS}, 32'h0, st);
    u_spl_host_model.xfer(1'b0, {24'h0, `SPL_OFF_RESULT}, 32'h0, rs);
    u_spl_host_model.xfer(1'b0, {24'h0, `SPL_OFF_MAP}, 32'h0, mp);
  endtask
  // Flags and code only move on success or error return
  task automatic chk(input spl_outcome_t oc, input logic [31:0] code, input logic zero);
    cmp("outcome", {28'h0, oc}, {28'h0, st[3:0]});
    cmp("carry", 32'h0, {31'h0, st[`SPL_STAT_CARRY_BIT]});
    cmp("map", {16'h0, emap}, mp);
    if (oc == SPL_OC_OK || oc == SPL_OC_ERR)
    begin
      cmp("zero", {31'h0, zero}, {31'h0, st[`SPL_STAT_ZERO_BIT]});
      cmp("code", code, rs);
    end
  endtask
  task automatic ok(input logic blk);
    emap = {1'b1, blk, sec[13:0]};
    chk(SPL_OC_OK, `SPL_CODE_OK, 1'b0);
  endtask
  task automatic pf(input logic [31:0] fa);
    go(`SPL_LEAF_BLK);
    chk(SPL_OC_PF, 32'h0, 1'b0);
    rdc("fault", `SPL_OFF_FAULT_ADDR, fa);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    emap = `SPL_RST_MAP;
    rdc("status", `SPL_OFF_STATUS, `SPL_RST_WORD);
    rdc("result", `SPL_OFF_RESULT, `SPL_RST_WORD);
    rdc("map", `SPL_OFF_MAP, {16'h0, `SPL_RST_MAP});
    wr(8'h60, 32'h5a5a_5a5a);
    rdc("unmapped", 8'h60, 32'h0);
    cmp("hresp", 32'h0, {31'h0, hresp});
    cmp("hreadyout", 32'h1, {31'h0, hreadyout});
  endtask
  task automatic t_success();
    base();
    wr(`SPL_OFF_VER_LO, 32'h0000_0011);
    rdc("counter", `SPL_OFF_COUNTER_HI, 32'h0000_0011);
    go(`SPL_LEAF_BLK);
    ok(1'b1);
    rdc("enclave_id", `SPL_OFF_HDR_ID, 32'h0000_00a5);
    rdc("entry_addr", `SPL_OFF_MAP_LIN, 32'h7000_0000);
    rdc("ver_lo", `SPL_OFF_VER_LO, 32'h0);
    rdc("ver_hi", `SPL_OFF_VER_HI, 32'h0);
  endtask
  task automatic t_leaves();
    logic [7:0] ty [5] = '{`SPL_PT_REGULAR, `SPL_PT_THREAD, `SPL_PT_TRIMMED, `SPL_PT_CONTROL,
      `SPL_PT_VERSION};
    logic par;
    for (int l = 0; l < 4; l++)
      for (int t = 0; t < 5; t++)
      begin
        base();
        par = t < 3;
        sec[7:0] = ty[t];
        cp = par ? cp : 32'h0;
        go(lf[l]);
        ok(par && (l == 0 || l == 2));
        rdc("enclave_id", `SPL_OFF_HDR_ID, par ? 32'h0000_00a5 : 32'h0);
        if (t == 3)
          rdc("context", `SPL_OFF_CONTEXT, dest);
      end
  endtask
  task automatic t_shadow();
    for (int f = 0; f < 2; f++)
      for (int t = 0; t < 2; t++)
      begin
        base();
        c.feat_ss = f[0];
        sec[7:0] = t ? `SPL_PT_SHADOW_REST : `SPL_PT_SHADOW_FIRST;
        go(`SPL_LEAF_UNBLK);
        if (f)
          ok(1'b0);
        else
          chk(SPL_OC_GP, 32'h0, 1'b0);
      end
  endtask
  task automatic t_gp();
    for (int k = 0; k < 10; k++)
    begin
      base();
      case (k)
        0: desc += 32'h10;
        1: dest += 32'h800;
        2: slot += 32'h4;
        3: meta += 32'h40;
        4: src += 32'h800;
        5: cp += 32'h800;
        6: sec[7:0] = `SPL_PT_CONTROL;
        7: c.cpl_zero = 1'b0;
        8: c.noncanonical = 1'b1;
        default: sec = sec;
      endcase
      go(k == 9 ? 8'h09 : `SPL_LEAF_BLK);
      chk(SPL_OC_GP, 32'h0, 1'b0);
    end
    base();
    c.noncanonical = 1'b1;
    c.long_mode = 1'b0;
    go(`SPL_LEAF_UNBLK);
    ok(1'b0);
  endtask
  task automatic t_pf();
    for (int k = 0; k < 6; k++)
    begin
      base();
      c.dest_in_cache = k != 0;
      c.slot_in_cache = k != 1;
      c.dest_valid = k == 2;
      c.slot_page_valid = k != 3;
      c.slot_is_version = k != 4;
      c.cpage_in_cache = k != 5;
      pf(k == 5 ? cp : (k == 0 || k == 2) ? dest : slot);
    end
  endtask
  task automatic t_conf();
    for (int l = 0; l < 4; l++)
      for (int k = 0; k < 4; k++)
      begin
        base();
        c.dest_conflict = k < 2;
        c.guest_ext = k[0];
        c.slot_conflict = k == 2;
        c.cpage_conflict = k == 3;
        go(lf[l]);
        if (k == 1)
        begin
          chk(l < 2 ? SPL_OC_VMX_EXC : SPL_OC_VMX_ERR, 32'h0, 1'b0);
          rdc("exit_addr", `SPL_OFF_FAULT_ADDR, dest);
        end
        else if (l < 2)
          chk(SPL_OC_GP, 32'h0, 1'b0);
        else
          chk(SPL_OC_ERR, `SPL_CODE_PAGE_CONFLICT, 1'b1);
      end
  endtask
  task automatic t_tag();
    base();
    tagc = ~tagc;
    go(`SPL_LEAF_UNBLK);
    chk(SPL_OC_ERR, `SPL_CODE_TAG_MISMATCH, 1'b1);
    rdc("ver_lo", `SPL_OFF_VER_LO, 32'h0000_0011);
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_success();
    t_leaves();
    t_shadow();
    t_gp();
    t_pf();
    t_conf();
    t_tag();
    conclude();
  end
endmodule

// file: test/spl_host_model.sv
// Bus master model standing in for privileged software
`timescale 1ns/1ps
module spl_host_model
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // AHB-Lite master side
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // ==========================================
  // Single word transfer
  // Write data flips outside its data phase so a stale value is never read
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
    output logic [31:0] q);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hwdata <= ~hwdata;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wr ? wd : ~wd;
    do @(posedge clk_sys); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule
